// File: logic/crc_gen_defs.vh
`ifndef CRC_GEN_DEFS_VH
`define CRC_GEN_DEFS_VH
// ==========================================================
// register byte addresses
`define A_CON1 12'h000
`define A_CON2 12'h004
`define A_MASKL 12'h008
`define A_MASKH 12'h00C
`define A_DATL 12'h010
`define A_DATH 12'h014
`define A_RESL 12'h018
`define A_RESH 12'h01C
// ==========================================================
// control one field positions
`define B_EN 15
`define B_SIDL 13
`define B_FUL 7
`define B_MPT 6
`define B_ISEL 5
`define B_GO 4
`define B_DIR 3
// control two field positions
`define F_DW_HI 12
`define F_DW_LO 8
`define F_PL_HI 4
`define F_PL_LO 0
// ==========================================================
// fifo depth thresholds and counts
`define DW_WIDE 5'h0F
`define DW_MID 5'h07
`define DEPTH_4 5'h04
`define DEPTH_8 5'h08
`define DEPTH_16 5'h10
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define PTR_ONE 4'h1
`define BIT_TWO 6'h02
`define ZERO_16 16'h0000
`define ZERO_32 32'h0000_0000
`define ZERO_4 4'h0
`define ZERO_5 5'h00
`define ZERO_6 6'h00
`define ONE_6 6'h01
`define MSB_IDX 5'h1F
`define WORD_BITS 6'h20
`endif

// File: logic/crc_gen.v
`include "crc_gen_defs.vh"
// Functional notes
// - length field 01111 selects 16th order, 11111 selects 32nd order
// - length field holds length minus one; width field holds width minus one
// - each set mask bit enables a feedback tap at that engine bit
// - zero-order term always applied; 32nd-order top term implied
// - input word width is any value from 1 to 32 bits
// - fifo depth 4 above 15, 8 for 8..15, 16 below 8
// - writes at least a byte; bits above configured width ignored
// - word counted when the byte holding its top bit is written
// - loading a word needs go set and words present; move decrements count
// - two bits per cycle, continuing until count is zero and the last word is shifted
// - full flag at depth for width; empty flag at zero count
// - enable low empties fifo, clears count, engine, result, high data
// - msb first by default; lsb first when direction bit set
// - direction changes input order only; result is not reflected
// - select 0: interrupt when count goes from one to zero
// - select 1: interrupt when hardware clears go; software clear silent
// - after count-zero interrupt, last word still shifting (width+1)/2 cycles
// - go bit cleared by hardware when calculation completes
// - stop-in-idle set halts shifting while device idles; fifo still accepts words
module crc_gen (
   input wire clk_i,
   input wire sys_rst_i,
   input wire idle_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   output reg irq_o
);
   // ==========================================================
   // registers
   reg en_q, sidl_q, isel_q, go_q, dir_q;
   reg [4:0] dw_q, pl_q;
   reg [31:0] mask_q, crc_q;
   reg [15:0] datl_q, dath_q;
   reg [31:0] fifo_q [0:15];
   reg [3:0] wp_q, rp_q;
   reg [4:0] cnt_q;
   reg [31:0] buf_q;
   reg [5:0] left_q;
   reg busy_q;
   wire wr = psel_i & penable_i & pwrite_i & ~pready_o;
   wire rd = psel_i & penable_i & ~pwrite_i & ~pready_o;
   wire run = en_q & ~(sidl_q & idle_i);
   // ==========================================================
   // fifo depth and word counting
   reg [4:0] depth;
   always @* begin
      if (dw_q > `DW_WIDE)
         depth = `DEPTH_4;
      else if (dw_q > `DW_MID)
         depth = `DEPTH_8;
      else
         depth = `DEPTH_16;
   end
   wire full = (cnt_q == depth);
   wire empty = (cnt_q == `CNT_ZERO);
   // top byte lane of word: width-1 bit 31..24 -> lane 3 etc.
   wire [1:0] top_lane = dw_q[4:3];
   wire top_hit = wr & ((paddr_i == `A_DATL & ~top_lane[1]
                  & pstrb_i[top_lane]) | (paddr_i == `A_DATH
                  & top_lane[1] & pstrb_i[top_lane]));
   wire push = top_hit & ~full & en_q;
   // ==========================================================
   // word assembly, bits above width masked out
   reg [31:0] wmask;
   reg [31:0] new_word;
   always @* begin
      wmask = {32{1'b1}} >> (`MSB_IDX - dw_q);
      new_word = {dath_q, datl_q};
      if (paddr_i == `A_DATL) begin
         if (pstrb_i[0])
            new_word[7:0] = pwdata_i[7:0];
         if (pstrb_i[1])
            new_word[15:8] = pwdata_i[15:8];
      end else begin
         if (pstrb_i[2])
            new_word[23:16] = pwdata_i[23:16];
         if (pstrb_i[3])
            new_word[31:24] = pwdata_i[31:24];
      end
      new_word = new_word & wmask;
   end
   wire load = run & go_q & ~busy_q & ~empty;
   wire pop = load;
   // ==========================================================
   // engine: two serial steps per cycle
   reg [31:0] c1, c2;
   reg d0, d1;
   wire [5:0] wlen = {1'b0, dw_q} + `ONE_6;
   function [31:0] step;
      input [31:0] c;
      input din;
      input [4:0] pl;
      input [31:0] m;
      reg fb;
      reg [31:0] sh;
      begin
         fb = c[pl] ^ din;
         sh = c << 1;
         // x0 always fed back; mask bit 0 ignored
         step = (sh ^ ({m[31:1], 1'b1} & {32{fb}}))
            & ({32{1'b1}} >> (`MSB_IDX - pl));
      end
   endfunction
   always @* begin
      // bit order into engine only; crc stays normal
      if (dir_q) begin
         d0 = buf_q[0];
         d1 = buf_q[1];
      end else begin
         d0 = buf_q[31];
         d1 = buf_q[30];
      end
      c1 = step(crc_q, d0, pl_q, mask_q);
      c2 = (left_q >= `BIT_TWO) ? step(c1, d1, pl_q, mask_q) : c1;
   end
   wire last = busy_q & (left_q <= `BIT_TWO);
   wire finish = run & last & empty & ~load;
   // ==========================================================
   // register select and read mux
   reg [31:0] rdata;
   reg mapped;
   always @* begin
      // unmapped offsets read zero and answer with an error
      rdata = `ZERO_32;
      mapped = 1'b1;
      case (paddr_i)
         `A_CON1: begin
            rdata = {`ZERO_16, en_q, 1'b0, sidl_q, cnt_q, full, empty,
               isel_q, go_q, dir_q, 3'h0};
         end
         `A_CON2: begin
            rdata = {19'h0_0000, dw_q, 3'h0, pl_q};
         end
         `A_MASKL: begin
            rdata = {`ZERO_16, mask_q[15:1], 1'b0};
         end
         `A_MASKH: begin
            rdata = {`ZERO_16, mask_q[31:16]};
         end
         `A_DATL: begin
            rdata = {`ZERO_16, datl_q};
         end
         `A_DATH: begin
            rdata = {`ZERO_16, dath_q};
         end
         `A_RESL: begin
            rdata = {`ZERO_16, crc_q[15:0]};
         end
         `A_RESH: begin
            rdata = {`ZERO_16, crc_q[31:16]};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   wire wr_con1 = wr & (paddr_i == `A_CON1);
   wire wr_con2 = wr & (paddr_i == `A_CON2);
   wire wr_maskl = wr & (paddr_i == `A_MASKL);
   wire wr_maskh = wr & (paddr_i == `A_MASKH);
   wire wr_datl = wr & (paddr_i == `A_DATL);
   wire wr_dath = wr & (paddr_i == `A_DATH);
   wire wr_resl = wr & (paddr_i == `A_RESL);
   wire wr_resh = wr & (paddr_i == `A_RESH);
   // engine ends its own run, as opposed to a software clear
   wire hw_done = finish & go_q;

   // ==========================================================
   // configuration, kept while disabled
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         en_q <= 1'b0;
         sidl_q <= 1'b0;
         isel_q <= 1'b0;
         dir_q <= 1'b0;
         dw_q <= `ZERO_5;
         pl_q <= `ZERO_5;
         mask_q <= `ZERO_32;
      end else begin
         if (wr_con1 & pstrb_i[1]) begin
            en_q <= pwdata_i[`B_EN];
            sidl_q <= pwdata_i[`B_SIDL];
         end
         if (wr_con1 & pstrb_i[0]) begin
            isel_q <= pwdata_i[`B_ISEL];
            dir_q <= pwdata_i[`B_DIR];
         end
         // new width sets depth at once; count is not trimmed
         if (wr_con2 & pstrb_i[1]) begin
            dw_q <= pwdata_i[`F_DW_HI:`F_DW_LO];
         end
         if (wr_con2 & pstrb_i[0]) begin
            pl_q <= pwdata_i[`F_PL_HI:`F_PL_LO];
         end
         if (wr_maskl) begin
            // bit 0 has no storage, x0 is always applied
            mask_q[15:1] <= pwdata_i[15:1];
         end
         if (wr_maskh) begin
            mask_q[31:16] <= pwdata_i[15:0];
         end
      end
   end

   // ==========================================================
   // start bit
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         go_q <= 1'b0;
      end else if (wr_con1 & pstrb_i[0]) begin
         // a software write beats the hardware clear
         go_q <= pwdata_i[`B_GO];
      end else if (hw_done) begin
         go_q <= 1'b0;
      end
   end

   // ==========================================================
   // data halves
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         datl_q <= `ZERO_16;
         dath_q <= `ZERO_16;
      end else begin
         if (wr_datl) begin
            datl_q <= new_word[15:0];
         end
         if (~en_q) begin
            dath_q <= `ZERO_16;
         end else if (wr_dath) begin
            dath_q <= new_word[31:16];
         end
      end
   end

   // ==========================================================
   // fifo storage, no reset: entries are read only once counted
   // a word written while full is dropped without an error
   always @(posedge clk_i) begin
      if (push) begin
         fifo_q[wp_q] <= new_word;
      end
   end

   // ==========================================================
   // pointers and valid-word count
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         wp_q <= `ZERO_4;
         rp_q <= `ZERO_4;
         cnt_q <= `CNT_ZERO;
      end else if (~en_q) begin
         // disabled: fifo emptied, pointers home
         wp_q <= `ZERO_4;
         rp_q <= `ZERO_4;
         cnt_q <= `CNT_ZERO;
      end else begin
         // pointers wrap at sixteen; depth only limits the count
         if (push) begin
            wp_q <= wp_q + `PTR_ONE;
         end
         if (pop) begin
            rp_q <= rp_q + `PTR_ONE;
         end
         cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
      end
   end

   // ==========================================================
   // word buffer and bit counter
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         buf_q <= `ZERO_32;
         left_q <= `ZERO_6;
         busy_q <= 1'b0;
      end else if (~en_q) begin
         left_q <= `ZERO_6;
         busy_q <= 1'b0;
      end else if (load) begin
         // one idle cycle between words, traded for a simple load
         busy_q <= 1'b1;
         left_q <= wlen;
         if (dir_q) begin
            buf_q <= fifo_q[rp_q];
         end else begin
            // top bit of the word lands at bit 31
            buf_q <= fifo_q[rp_q] << (`WORD_BITS - wlen);
         end
      end else if (run & busy_q) begin
         if (dir_q) begin
            buf_q <= buf_q >> `BIT_TWO;
         end else begin
            buf_q <= buf_q << `BIT_TWO;
         end
         if (left_q >= `BIT_TWO) begin
            left_q <= left_q - `BIT_TWO;
         end else begin
            left_q <= `ZERO_6;
         end
         if (last) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // result register
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         crc_q <= `ZERO_32;
      end else if (~en_q) begin
         crc_q <= `ZERO_32;
      end else begin
         if (run & busy_q) begin
            crc_q <= c2;
         end
         if (wr_resl) begin
            // a write lands after the step, so it wins
            crc_q[15:0] <= pwdata_i[15:0];
         end
         if (wr_resh) begin
            crc_q[31:16] <= pwdata_i[15:0];
         end
      end
   end

   // ==========================================================
   // interrupt pulse
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_o <= 1'b0;
      end else if (~isel_q) begin
         irq_o <= pop & ~push & (cnt_q == `CNT_ONE);
      end else begin
         // software clear of go stays silent
         irq_o <= hw_done;
      end
   end

   // ==========================================================
   // apb response
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= `ZERO_32;
      end else begin
         // one wait state; ready drops after a single cycle
         pready_o <= psel_i & penable_i & ~pready_o;
         if (wr | rd) begin
            pslverr_o <= ~mapped;
         end else begin
            pslverr_o <= 1'b0;
         end
         if (rd) begin
            prdata_o <= rdata;
         end
      end
   end
endmodule // crc_gen

// File: sim/crc_gen_asserts.sv
`include "crc_gen_defs.vh"
module crc_gen_asserts (
   input wire clk_i,
   input wire sys_rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // control one read helper
   wire rd0 = pready_o & ~pwrite_i & (paddr_i == `A_CON1);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
   a_wait: assert property (p_wait) else $error("no ready after wait");
   property p_pulse; pready_o |=> !pready_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_err; pready_o |-> pslverr_o == (paddr_i > `A_RESH); endproperty
   a_err: assert property (p_err) else $error("bad error reply");
   property p_irq; irq_o |=> !irq_o; endproperty
   a_irq: assert property (p_irq) else $error("irq not a pulse");
   property p_flags; rd0 |-> !(prdata_o[7] && prdata_o[6]); endproperty
   a_flags: assert property (p_flags) else $error("full and empty");
   property p_mpt; rd0 |-> prdata_o[6] == (prdata_o[12:8] == 5'h00);
   endproperty
   a_mpt: assert property (p_mpt) else $error("empty flag wrong");
   property p_off; rd0 && !prdata_o[15] |-> prdata_o[12:8] == 5'h00;
   endproperty
   a_off: assert property (p_off) else $error("count while off");
   property p_max; rd0 |-> prdata_o[12:8] <= 5'h10; endproperty
   a_max: assert property (p_max) else $error("count over depth");
   c_wait: cover property (psel_i && penable_i && !pready_o);
   c_irq: cover property (irq_o);
   c_err: cover property (pslverr_o);
endmodule // crc_gen_asserts
bind crc_gen crc_gen_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .irq_o(irq_o));

// File: sim/tb.sv
`include "crc_gen_defs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, sys_rst_i = 1, idle_i = 0, psel_i = 0, penable_i = 0;
   logic pwrite_i = 0, pready_o, pslverr_o, irq_o, irq_seen = 0, err;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
   logic [3:0] pstrb_i = 4'h0;
   int err_count = 0, compares = 0;
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (irq_o === 1'b1) irq_seen <= 1'b1;
   crc_gen DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .idle_i(idle_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .irq_o(irq_o));
   // ==========================================
   // shared tasks
   task chk(input logic [31:0] seen, exp, input string what);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n = 0;
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge clk_i);
      penable_i <= 1;
      // sampled before this edge's updates land
      do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
      if (n >= 50) begin
         err_count++;
         end_of_test;
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   function automatic logic [15:0] crc16(input logic [15:0] w, input logic l);
      logic [15:0] c = 16'h0000;
      logic b;
      for (int i = 15; i >= 0; i--) begin
         b = (l ? w[15 - i] : w[i]) ^ c[15];
         c = {c[14:0], 1'b0} ^ (b ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction
   // ==========================================
   // scenarios
   task automatic t_crc(input logic l);
      wr(`A_CON1, 32'h0000_8000);
      wr(`A_CON2, 32'h0000_0F0F);
      wr(`A_MASKL, 32'h0000_1020); // zero term left clear on purpose
      wr(`A_MASKH, 32'h0000_0000);
      wr(`A_RESL, 32'h0000_0000);
      wr(`A_RESH, 32'h0000_0000);
      apb(1'b1, `A_DATL, 32'h0000_C3A5, 4'h3);
      apb(1'b0, `A_CON1, 32'h0000_0000, 4'h0);
      chk(rd[12:8], 32'h0000_0001, "count");
      irq_seen = 0;
      wr(`A_CON1, 32'h0000_8010 | {l, 5'h00} | {l, 3'h0});
      for (int n = 0; n < 20; n++) begin
         apb(1'b0, `A_CON1, 32'h0000_0000, 4'h0);
         if (rd[4] === 1'b0) break;
      end
      chk(rd[4], 32'h0000_0000, "go");
      chk(irq_seen, 32'h0000_0001, "irq");
      apb(1'b0, `A_RESL, 32'h0000_0000, 4'h0);
      chk(rd[15:0], crc16(16'hC3A5, l), "crc");
   endtask
   task automatic t_depth;
      logic [4:0] dw [3] = '{5'h1F, 5'h0F, 5'h07};
      logic [4:0] d5;
      for (int k = 0; k < 3; k++) begin
         d5 = 5'h04 << k;
         wr(`A_CON1, 32'h0000_8000);
         wr(`A_CON2, {19'h0, dw[k], 8'h00});
         // one word beyond depth is dropped
         for (int j = 0; j <= d5; j++) begin
            apb(1'b1, `A_DATL, 32'h0000_ABFF, 4'h3);
            if (dw[k] > 5'h0F)
               apb(1'b1, `A_DATH, 32'h5A5A_0000, 4'hC);
         end
         apb(1'b0, `A_CON1, 32'h0000_0000, 4'h0);
         chk(rd[12:6], {d5, 2'b10}, "full");
         apb(1'b0, `A_DATL, 32'h0000_0000, 4'h0);
         chk(rd, (k == 2) ? 32'h0000_00FF : 32'h0000_ABFF, "mask");
         wr(`A_CON1, 32'h0000_0000);
         apb(1'b0, `A_CON1, 32'h0000_0000, 4'h0);
         chk(rd[12:6], 32'h0000_0001, "off");
         apb(1'b0, `A_DATH, 32'h0000_0000, 4'h0);
         chk(rd, 32'h0000_0000, "dath off");
         apb(1'b0, `A_RESL, 32'h0000_0000, 4'h0);
         chk(rd[15:0], 32'h0000_0000, "res off");
      end
   endtask
   task end_of_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 0;
      apb(1'b0, `A_CON1, 32'h0000_0000, 4'h0);
      chk(rd, 32'h0000_0040, "reset");
      apb(1'b0, 12'h020, 32'h0000_0000, 4'h0);
      chk(err, 32'h0000_0001, "unmapped");
      t_crc(1'b0);
      t_crc(1'b1);
      t_depth;
      end_of_test;
   end
   initial begin
      #200000;
      err_count++;
      end_of_test;
   end
endmodule // tb
